/* File: swr_pkg.sv */
package swr_pkg;
   // ------------------------------------------------------------------
   // Frame layout
   // ------------------------------------------------------------------
   localparam int          SWR_WORD_W    = 24;
   localparam int          SWR_ADDR_W    = 6;
   localparam int          SWR_DEPTH     = 64;
   localparam logic [7:0]  SWR_CMD_WORD  = 8'h01;
   localparam logic [1:0]  SWR_CODE_RD   = 2'h0;
   localparam logic [1:0]  SWR_CODE_WR   = 2'h2;
   localparam logic [2:0]  SWR_BIT_LAST  = 3'h7;
   localparam logic [2:0]  SWR_BYTE_CMD  = 3'h0;
   localparam logic [2:0]  SWR_BYTE_ADR  = 3'h1;
   localparam logic [2:0]  SWR_BYTE_D0   = 3'h2;
   localparam logic [2:0]  SWR_BYTE_D2   = 3'h4;
   localparam logic [2:0]  SWR_BYTE_DONE = 3'h5;

   // ------------------------------------------------------------------
   // Transaction kinds
   // ------------------------------------------------------------------
   typedef enum logic [1:0] {
      SWR_IDLE  = 2'b00,
      SWR_READ  = 2'b01,
      SWR_WRITE = 2'b10,
      SWR_SKIP  = 2'b11
   } swr_mode_e;
endpackage : swr_pkg

/* File: swr_sync.sv */
module swr_sync
   import swr_pkg::*;
#(
   parameter int WIDTH = 3
) (
   // Clock and reset
   input  wire logic             clk,
   input  wire logic             reset,
   // Asynchronous levels in, settled levels out
   input  wire logic [WIDTH-1:0] async_in,
   input  wire logic [WIDTH-1:0] init_val,
   output logic      [WIDTH-1:0] sync_out
);
   typedef struct packed {
      logic [WIDTH-1:0] meta;
      logic [WIDTH-1:0] sync;
   } swr_sync_s;

   swr_sync_s st_q;
   swr_sync_s st_d;

   // ------------------------------------------------------------------
   // Two stages; only the second stage is read outside
   // ------------------------------------------------------------------
   always_comb begin
      st_d      = st_q;
      st_d.meta = async_in;
      st_d.sync = st_q.meta;
   end

   // Reset takes the idle pin levels so no false edge follows release
   always_ff @(posedge clk) begin
      if (reset) begin
         st_q.meta <= init_val;
         st_q.sync <= init_val;
      end else begin
         st_q <= st_d;
      end
   end

   assign sync_out = st_q.sync;
endmodule : swr_sync

/* File: swr_slave.sv */
module swr_slave
   import swr_pkg::*;
#(
   parameter int WORD_W = SWR_WORD_W,
   parameter int ADDR_W = SWR_ADDR_W
) (
   // Clock and reset
   input  wire logic clk,
   input  wire logic reset,
   // Serial link pins; the inputs come from the host's domain, data out and its enable from ours
   input  wire logic chip_select_n,
   input  wire logic sck,
   input  wire logic serial_in,
   output logic      serial_out,
   output logic      serial_out_oe
);
   localparam int DEPTH = 1 << ADDR_W;

   // Elaboration-time check: the frame carries exactly 24 bits and 6 address bits
   if (WORD_W != SWR_WORD_W || ADDR_W != SWR_ADDR_W || DEPTH != SWR_DEPTH) begin : g_chk
      $error("swr_slave: word must be 24 bits and address 6 bits");
   end

   typedef struct packed {
      logic              sck_prev;
      logic [2:0]        bit_cnt;
      logic [2:0]        byte_cnt;
      logic [7:0]        shift_in;
      swr_mode_e         mode;
      logic [ADDR_W-1:0] addr;
      logic [WORD_W-1:0] shift_out;
      logic              out_bit;
      logic              oe;
      logic              wr_en;
      logic [ADDR_W-1:0] wr_addr;
      logic [WORD_W-1:0] wr_data;
   } swr_state_s;

   swr_state_s        st_q;
   swr_state_s        st_d;
   logic [2:0]        pins_s;
   logic              cs_n_s;
   logic              sck_s;
   logic              sdi_s;
   logic              rise;
   logic              fall;
   logic [7:0]        byte_now;
   logic [WORD_W-1:0] mem [DEPTH];
   logic [WORD_W-1:0] rd_word;

   // ------------------------------------------------------------------
   // Pin synchronisers
   // ------------------------------------------------------------------
   swr_sync #(.WIDTH(3)) u_sync (
      .clk      (clk),
      .reset    (reset),
      .async_in ({chip_select_n, sck, serial_in}),
      .init_val (3'h7),
      .sync_out (pins_s)
   );

   assign cs_n_s = pins_s[2];
   assign sck_s  = pins_s[1];
   assign sdi_s  = pins_s[0];

   // Edges of the host clock, found on our clock; only sampled when selected
   assign rise     = !cs_n_s && sck_s && !st_q.sck_prev;
   assign fall     = !cs_n_s && !sck_s && st_q.sck_prev;
   assign byte_now = {st_q.shift_in[6:0], sdi_s};
   assign rd_word  = mem[st_q.addr];

   // ------------------------------------------------------------------
   // Serial engine
   // ------------------------------------------------------------------
   // Nothing advances without an edge, so clock pauses simply hold state
   always_comb begin
      st_d          = st_q;
      st_d.sck_prev = sck_s;
      st_d.wr_en    = 1'b0;
      if (cs_n_s) begin
         // Select released: fresh frame next time, partial write dropped
         st_d.bit_cnt  = '0;
         st_d.byte_cnt = SWR_BYTE_CMD;
         st_d.mode     = SWR_IDLE;
         st_d.oe       = 1'b0;
         st_d.out_bit  = 1'b1;
      end else begin
         if (rise) begin
            st_d.shift_in = byte_now;
            st_d.bit_cnt  = st_q.bit_cnt + 3'h1;
            if (st_q.bit_cnt == SWR_BIT_LAST) begin
               if (st_q.byte_cnt != SWR_BYTE_DONE) begin
                  st_d.byte_cnt = st_q.byte_cnt + 3'h1;
               end
               unique case (st_q.byte_cnt)
                  SWR_BYTE_CMD: begin
                     // Unknown command: ignore rest of frame
                     st_d.mode = (byte_now == SWR_CMD_WORD) ? SWR_IDLE : SWR_SKIP;
                  end
                  SWR_BYTE_ADR: begin
                     st_d.addr = byte_now[7 -: ADDR_W];
                     if (st_q.mode == SWR_SKIP) begin
                        st_d.mode = SWR_SKIP;
                     end else if (byte_now[1:0] == SWR_CODE_RD) begin
                        st_d.mode = SWR_READ;
                     end else if (byte_now[1:0] == SWR_CODE_WR) begin
                        st_d.mode = SWR_WRITE;
                     end else begin
                        st_d.mode = SWR_SKIP;
                     end
                  end
                  default: begin
                     // Data bytes: collect write data MSB first
                     if (st_q.mode == SWR_WRITE) begin
                        st_d.wr_data = {st_q.wr_data[WORD_W-9:0], byte_now};
                        if (st_q.byte_cnt == SWR_BYTE_D2) begin
                           st_d.wr_en   = 1'b1;
                           st_d.wr_addr = st_q.addr;
                        end
                     end
                  end
               endcase
            end
         end
         if (fall) begin
            // Output moves only on falling edges, and only for read data
            if (st_q.mode == SWR_READ && st_q.byte_cnt >= SWR_BYTE_D0
                && st_q.byte_cnt < SWR_BYTE_DONE) begin
               if (st_q.byte_cnt == SWR_BYTE_D0 && st_q.bit_cnt == '0) begin
                  st_d.out_bit   = rd_word[WORD_W-1];
                  st_d.shift_out = {rd_word[WORD_W-2:0], 1'b0};
               end else begin
                  st_d.out_bit   = st_q.shift_out[WORD_W-1];
                  st_d.shift_out = {st_q.shift_out[WORD_W-2:0], 1'b0};
               end
               st_d.oe = 1'b1;
            end else begin
               st_d.oe = 1'b0;
            end
         end
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         st_q           <= '0;
         st_q.sck_prev  <= 1'b1;
         st_q.out_bit   <= 1'b1;
         st_q.mode      <= SWR_IDLE;
      end else begin
         st_q <= st_d;
      end
   end

   // ------------------------------------------------------------------
   // Word memory, written once per complete write frame
   // ------------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (st_q.wr_en) begin
         mem[st_q.wr_addr] <= st_q.wr_data;
      end
   end

   // Pins never drive clock or select; only data out is ours
   assign serial_out    = st_q.out_bit;
   assign serial_out_oe = st_q.oe;

   // ------------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------------
   sequence s_deselect;
      cs_n_s;
   endsequence

   property p_out_off_write;
      @(posedge clk) disable iff (reset)
      (st_q.mode == SWR_WRITE) |-> !serial_out_oe;
   endproperty
   a_out_off_write: assert property (p_out_off_write)
      else $error("output driven in write");

   property p_out_off_cmd;
      @(posedge clk) disable iff (reset)
      (st_q.byte_cnt < SWR_BYTE_D0) |-> !serial_out_oe;
   endproperty
   a_out_off_cmd: assert property (p_out_off_cmd)
      else $error("output driven in command");

   property p_counters_clear;
      @(posedge clk) disable iff (reset)
      s_deselect |=> (st_q.bit_cnt == '0 && st_q.byte_cnt == SWR_BYTE_CMD);
   endproperty
   a_counters_clear: assert property (p_counters_clear)
      else $error("counters not cleared");

   property p_wr_full;
      @(posedge clk) disable iff (reset)
      st_q.wr_en |-> ($past(st_q.byte_cnt) == SWR_BYTE_D2 && st_q.mode == SWR_WRITE);
   endproperty
   a_wr_full: assert property (p_wr_full) else $error("write before 24 bits");

   property p_out_on_fall;
      @(posedge clk) disable iff (reset)
      $changed(serial_out) && !cs_n_s |-> $past(fall);
   endproperty
   a_out_on_fall: assert property (p_out_on_fall)
      else $error("output moved off falling edge");

   property p_hold_pause;
      @(posedge clk) disable iff (reset)
      (!cs_n_s && !rise) |=> $stable(st_q.bit_cnt);
   endproperty
   a_hold_pause: assert property (p_hold_pause)
      else $error("count moved with no edge");

   property p_read_msb;
      @(posedge clk) disable iff (reset)
      (fall && st_q.mode == SWR_READ && st_q.byte_cnt == SWR_BYTE_D0 && st_q.bit_cnt == '0)
      |=> (serial_out == $past(rd_word[WORD_W-1]) && serial_out_oe);
   endproperty
   a_read_msb: assert property (p_read_msb) else $error("read word MSB not first");

   property p_wr_lands;
      @(posedge clk) disable iff (reset)
      st_q.wr_en |=> mem[$past(st_q.wr_addr)] == $past(st_q.wr_data);
   endproperty
   a_wr_lands: assert property (p_wr_lands) else $error("write not stored");
endmodule : swr_slave

/* File: swr_host_model.sv */
module swr_host_model (
   // Host-driven link pins
   output logic chip_select_n,
   output logic sck,
   output logic serial_in,
   // Device data line and its enable
   input  logic serial_out,
   input  logic serial_out_oe
);
   timeunit 1ns;
   timeprecision 100ps;
   // ------------------------------------------------------------------
   // Host side of the link: owns select, clock and input data
   // ------------------------------------------------------------------
   logic last_q;
   wire  line_lvl = serial_out_oe ? serial_out : ~last_q;

   // Idle levels: select released, clock high between frames
   initial begin
      chip_select_n = 1'b1;
      sck           = 1'b1;
      serial_in     = 1'b1;
      last_q        = 1'b1;
   end

   // Undriven line shows the inverse of its last value, never a kind 0
   always @* if (serial_out_oe === 1'b1) last_q = serial_out;

   // One frame; nbits below 40 releases select early, pause_at holds sck high
   task automatic frame(input logic [7:0] b0, b1, input logic [23:0] wd,
                        input int nbits, pause_at, input bit wr,
                        output logic [23:0] rd, output bit oe_bad);
      logic [39:0] sh;
      sh     = {b0, b1, wd}; // Command, address and code, data
      rd     = 24'h00_0000;
      oe_bad = 1'b0;
      chip_select_n = 1'b0; // Held low for the whole frame
      #62.5;
      for (int i = 0; i < nbits; i++) begin
         if (i == pause_at) #3000;
         sck       = 1'b0;
         serial_in = sh[39-i]; // MSB first, changed on falling edge
         #62.5;
         sck = 1'b1; // Sample on rising edge
         if (i >= 16) rd = {rd[22:0], line_lvl};
         if (serial_out_oe !== ((i >= 16 && !wr) ? 1'b1 : 1'b0)) oe_bad = 1'b1;
         #62.5;
      end
      chip_select_n = 1'b1; // Ends the frame
      serial_in     = ~serial_in;
      #100;
   endtask : frame
endmodule : swr_host_model

/* File: testbench.sv */
module testbench;
   timeunit 1ns;
   timeprecision 100ps;
   import swr_pkg::*;
   // ------------------------------------------------------------------
   // Signals and reference memory
   // ------------------------------------------------------------------
   logic        clk   = 1'b0;
   logic        reset = 1'b1;
   logic        chip_select_n;
   logic        sck;
   logic        serial_in;
   logic        serial_out;
   logic        serial_out_oe;
   logic [23:0] ref_mem [SWR_DEPTH];
   int          n_fail       = 0;
   int          total_checks = 0;
   int          seed         = 57352;

   always #5 clk = ~clk;

   swr_slave u_dut (.clk(clk), .reset(reset), .chip_select_n(chip_select_n), .sck(sck),
                    .serial_in(serial_in), .serial_out(serial_out),
                    .serial_out_oe(serial_out_oe));

   swr_host_model u_host (
      .chip_select_n (chip_select_n),
      .sck           (sck),
      .serial_in     (serial_in),
      .serial_out    (serial_out),
      .serial_out_oe (serial_out_oe)
   );

   // ------------------------------------------------------------------
   // Compare, transfer and closing tasks
   // ------------------------------------------------------------------
   task automatic check(input string what, input logic [23:0] seen, exp);
      total_checks++;
      if (seen !== exp) begin
         n_fail++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   task automatic wr(input logic [5:0] a, input logic [23:0] d, input int nb, pause);
      logic [23:0] rd;
      bit          bad;
      u_host.frame(SWR_CMD_WORD, {a, SWR_CODE_WR}, d, nb, pause, 1'b1, rd, bad);
      if (nb == 40) ref_mem[a] = d; // Partial frames must leave the word alone
      check("write oe", {23'h00_0000, bad}, 24'h00_0000);
   endtask : wr

   task automatic rd_chk(input logic [5:0] a, input int pause);
      logic [23:0] rd;
      bit          bad;
      u_host.frame(SWR_CMD_WORD, {a, SWR_CODE_RD}, 24'h00_0000, 40, pause, 1'b0, rd, bad);
      check("read oe", {23'h00_0000, bad}, 24'h00_0000);
      check("read data", rd, ref_mem[a]);
   endtask : rd_chk

   task automatic give_verdict;
      $display("checks %0d mismatches %0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask : give_verdict

   // Watchdog cuts a hang short
   initial begin
      #900us;
      n_fail++;
      $display("timeout");
      give_verdict;
   end

   // ------------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------------
   initial begin
      logic [5:0]  a;
      logic [23:0] rd;
      bit          bad;
      repeat (20) @(posedge clk);
      #1 reset = 1'b0;
      repeat (3) @(posedge clk);
      #1 check("idle", {22'h00_0000, serial_out, serial_out_oe}, 24'h00_0002);
      $display("reset test done");
      // Boundary addresses first, then random words
      for (int i = 0; i < 10; i++) begin
         a = (i == 0) ? 6'h00 : (i == 1) ? 6'h3F : 6'($random(seed));
         wr(a, 24'($random(seed)), 40, -1);
         rd_chk(a, -1);
      end
      $display("random test done");
      // Back-to-back frames with neighbouring words
      wr(6'h05, 24'($random(seed)), 40, -1);
      wr(6'h06, 24'($random(seed)), 40, -1);
      rd_chk(6'h05, -1);
      rd_chk(6'h06, -1);
      $display("back to back test done");
      // Long clock pauses inside data bytes
      wr(6'h07, 24'($random(seed)), 40, 21);
      rd_chk(6'h07, 30);
      $display("pause test done");
      // Early release drops the partial write; next frame starts afresh
      foreach (ref_mem[k]) if (k < 3) begin
         wr(6'h07, 24'($random(seed)), (k == 0) ? 8 : (k == 1) ? 16 : 39, -1);
         rd_chk(6'h07, -1);
      end
      $display("abort test done");
      // Mid-run reset between frames: outputs go idle, stored words survive
      @(posedge clk);
      #1 reset = 1'b1;
      repeat (2) @(posedge clk);
      #1 reset = 1'b0;
      repeat (3) @(posedge clk);
      #1 check("idle again", {22'h00_0000, serial_out, serial_out_oe}, 24'h00_0002);
      rd_chk(6'h07, -1);
      $display("second reset test done");
      // Wrong command byte and unknown codes are ignored without drive
      for (int i = 0; i < 3; i++) begin
         u_host.frame((i == 0) ? 8'h02 : SWR_CMD_WORD,
                      {6'h07, (i == 0) ? SWR_CODE_WR : 2'(i * 2 - 1)},
                      24'($random(seed)), 40, -1, 1'b1, rd, bad);
         check("refused oe", {23'h00_0000, bad}, 24'h00_0000);
         rd_chk(6'h07, -1);
      end
      $display("refusal test done");
      give_verdict;
   end
endmodule : testbench
